// [logic/led_pump_mode_control.sv]
// Purpose: pump mode state machine, switch sequencing and channel DAC control
// Assumes: all inputs synchronous to clock_i; serial framing lives elsewhere
// Notes: long timers are parameters so simulation can shorten them
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "led_pump_regs.svh"
module led_pump_mode_control
    import led_pump_pkg::*;
#(
    parameter int DROP_QUAL_CYC  = `DROPOUT_QUAL_CYC,
    parameter int SOFT_START_CYC = `SOFT_START_CYC
)
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        load_pulse_i,
    input  wire logic        logic_supply_ok_i,
    input  wire logic        external_enable_input_i,
    input  wire logic [8:0]  dropout_i,
    input  wire logic        ramp_down_done_i,
    input  wire logic        blink_period_i,
    output logic [53:0]      dac_code_o,
    output logic [8:0]       source_enable_o,
    output logic [8:0]       open_drain_mode_o,
    output logic [8:0]       open_drain_pull_o,
    output logic [2:0]       pump_mode_o,
    output logic             shutdown_o,
    output logic [7:0]       soft_start_level_o,
    output logic             phase1_o,
    output logic             phase2_o,
    output logic             bypass_o,
    output logic             weak_bypass_o,
    output logic             series_charge_o,
    output logic             parallel_stack_o,
    output logic             fly_a_charge_o,
    output logic             fly_b_charge_o
);

    localparam int HALF = `PUMP_HALF_CYC;

    function automatic logic is_gpo(input data_t d);
        is_gpo = (d[7:6] == `GPO_BITS);
    endfunction

    function automatic logic is_source_on(input data_t d);
        is_source_on = !is_gpo(d) && (d[5:0] != 6'h00);
    endfunction

    // held settings written by software, and the copies the DACs use
    data_t       held_q [0:11];
    data_t       act_q  [0:11];
    logic        enu_q;
    logic [8:0]  enu_sel;
    logic [8:0]  active;
    logic [8:0]  considered;
    logic        any_drop;
    logic        any_other;
    logic        enu_fall;
    logic        to_unity;
    logic        drop_hit;
    logic        shutdown;
    logic        forced;
    pump_mode_t  force_mode;
    pump_mode_t  auto_q;
    pump_mode_t  auto_d;
    pump_mode_t  eff_mode;
    pump_mode_t  eff_q;
    logic [31:0] drop_cnt_q;
    logic [31:0] ss_cnt_q;
    logic [7:0]  ss_level;
    logic [5:0]  ph_cnt_q;
    logic        ph1;
    logic        ph2;

    assign enu_sel = {act_q[`ADDR_ENABLE_SEL_HI][0], act_q[`ADDR_ENABLE_SEL]};

    always_comb
    begin
        active     = '0;
        considered = '0;
        any_other  = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            // enable-pin channels light only while the pin is high
            active[i] = is_source_on(act_q[i + 1]) &&
                        (!enu_sel[i] || external_enable_input_i);                // see [R12]
            // zero code, open-drain and gated channels never count
            considered[i] = active[i] && dropout_i[i];                          // see [R7] [R11]
            if (is_source_on(act_q[i + 1]) && !enu_sel[i])
            begin
                any_other = 1'b1;
            end
        end
    end

    assign any_drop = |considered;
    assign enu_fall = enu_q && !external_enable_input_i;
    // falling enable only matters while other outputs stay lit
    assign to_unity = load_pulse_i || ramp_down_done_i || blink_period_i ||
                      (enu_fall && any_other);                                   // see [R5]
    assign drop_hit = any_drop && (drop_cnt_q >= 32'(DROP_QUAL_CYC - 1));

    // forced modes come straight from command bits D2/D3
    always_comb
    begin
        forced     = act_q[`ADDR_COMMAND][`CMD_FORCE_HALF_BIT] |
                     act_q[`ADDR_COMMAND][`CMD_FORCE_DBL_BIT];
        force_mode = MODE_1X;
        case ({act_q[`ADDR_COMMAND][`CMD_FORCE_DBL_BIT],
               act_q[`ADDR_COMMAND][`CMD_FORCE_HALF_BIT]})
            2'b01:   force_mode = MODE_HALF;                                     // see [R19]
            2'b10:   force_mode = MODE_DBL;                                      // see [R19]
            default: force_mode = MODE_1X;                                       // see [R19]
        endcase
    end

    // shutdown only in auto mode with nothing lit
    assign shutdown = !forced && (active == 9'h000);                            // see [R13]
    assign eff_mode = forced ? force_mode : auto_q;                              // see [R6]

    always_comb
    begin
        auto_d = auto_q;
        case (auto_q)
            MODE_1X:
            begin
                if (drop_hit)
                begin
                    auto_d = MODE_HALF;                                          // see [R2]
                end
            end
            MODE_HALF:
            begin
                if (drop_hit)
                begin
                    auto_d = MODE_DBL;                                           // see [R3]
                end
            end
            MODE_DBL:
            begin
                auto_d = MODE_DBL;                                               // see [R22]
            end
            default:
            begin
                auto_d = MODE_1X;
            end
        endcase
        if (to_unity || shutdown)
        begin
            auto_d = MODE_1X;                                                    // see [R1] [R5]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            auto_q <= MODE_1X;                                                   // see [R1]
        end
        else
        begin
            auto_q <= auto_d;
        end
    end

    // persistence timer
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            drop_cnt_q <= '0;
        end
        else if (!any_drop || drop_hit || to_unity || forced)
        begin
            drop_cnt_q <= '0;                                                    // see [R21]
        end
        else
        begin
            drop_cnt_q <= drop_cnt_q + 32'd1;                                    // see [R4]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enu_q <= 1'b0;
        end
        else
        begin
            enu_q <= external_enable_input_i;
        end
    end

    // register writes; the quick-write bit fans channel one out to all nine
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 12; i++)
            begin
                held_q[i] <= `DATA_RESET;
            end
        end
        else if (!logic_supply_ok_i)
        begin
            for (int i = 0; i < 12; i++)
            begin
                held_q[i] <= `DATA_RESET;                                        // see [R14]
            end
        end
        else if (wr_i && addr_i <= `ADDR_ENABLE_SEL_HI)
        begin
            if (addr_i == `ADDR_CH_FIRST && held_q[`ADDR_COMMAND][`CMD_QUICK_BIT])
            begin
                for (int i = 1; i < 10; i++)
                begin
                    held_q[i] <= wdata_i;
                end
            end
            else
            begin
                held_q[addr_i] <= wdata_i;
            end
        end
    end

    // settings only reach the DACs on the load pulse after stop
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 12; i++)
            begin
                act_q[i] <= `DATA_RESET;
            end
        end
        else if (!logic_supply_ok_i)
        begin
            for (int i = 0; i < 12; i++)
            begin
                act_q[i] <= `DATA_RESET;                                         // see [R14]
            end
        end
        else if (load_pulse_i)
        begin
            for (int i = 0; i < 12; i++)
            begin
                act_q[i] <= held_q[i];                                           // see [R20]
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            if (addr_i <= `ADDR_ENABLE_SEL_HI)
            begin
                rdata_o <= held_q[addr_i];
            end
            else if (addr_i == `ADDR_STATUS)
            begin
                rdata_o <= {4'h0, shutdown_o, pump_mode_o};
            end
            else
            begin
                rdata_o <= 8'h00;
            end
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // soft-start restarts whenever the effective mode enters a boost step
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            eff_q    <= MODE_1X;
            ss_cnt_q <= '0;
        end
        else
        begin
            eff_q <= shutdown ? MODE_1X : eff_mode;
            if (shutdown || eff_mode == MODE_1X)
            begin
                ss_cnt_q <= '0;
            end
            else if (eff_mode != eff_q)
            begin
                ss_cnt_q <= '0;                                                  // see [R15]
            end
            else if (ss_cnt_q < 32'(SOFT_START_CYC))
            begin
                ss_cnt_q <= ss_cnt_q + 32'd1;                                    // see [R15]
            end
        end
    end

    // linear ramp, saturates at full strength
    assign ss_level = (ss_cnt_q >= 32'(SOFT_START_CYC)) ? 8'hFF :
                      8'((64'(ss_cnt_q) * 64'd255) / 64'(SOFT_START_CYC));

    // free-running phase counter; slot 0 and HALF are dead time
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ph_cnt_q <= '0;
        end
        else if (ph_cnt_q >= 6'(2 * HALF - 1))
        begin
            ph_cnt_q <= '0;                                                      // see [R16]
        end
        else
        begin
            ph_cnt_q <= ph_cnt_q + 6'd1;
        end
    end

    assign ph1 = (ph_cnt_q != 6'd0) && (ph_cnt_q < 6'(HALF));                   // see [R16]
    assign ph2 = (ph_cnt_q > 6'(HALF));                                          // see [R16]

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase1_o         <= 1'b0;
            phase2_o         <= 1'b0;
            bypass_o         <= 1'b0;
            weak_bypass_o    <= 1'b1;
            series_charge_o  <= 1'b0;
            parallel_stack_o <= 1'b0;
            fly_a_charge_o   <= 1'b0;
            fly_b_charge_o   <= 1'b0;
            pump_mode_o      <= MODE_1X;
            shutdown_o       <= 1'b1;
            soft_start_level_o <= 8'h00;
        end
        else
        begin
            phase1_o         <= ph1;
            phase2_o         <= ph2;
            shutdown_o       <= shutdown;
            pump_mode_o      <= eff_mode;
            soft_start_level_o <= (shutdown || eff_mode == MODE_1X) ? 8'h00 : ss_level;
            // in shutdown only the weak path charges the output capacitor
            weak_bypass_o    <= shutdown;                                        // see [R18]
            bypass_o         <= !shutdown && eff_mode == MODE_1X;                // see [R1] [R18]
            series_charge_o  <= !shutdown && eff_mode == MODE_HALF && ph1;       // see [R17]
            parallel_stack_o <= !shutdown && eff_mode == MODE_HALF && ph2;       // see [R17]
            // alternate-phase charging keeps output ripple low
            fly_a_charge_o   <= !shutdown && eff_mode == MODE_DBL && ph1;        // see [R17]
            fly_b_charge_o   <= !shutdown && eff_mode == MODE_DBL && ph2;        // see [R17]
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dac_code_o        <= '0;
            source_enable_o   <= '0;
            open_drain_mode_o <= '0;
            open_drain_pull_o <= '0;
        end
        else
        begin
            for (int i = 0; i < 9; i++)
            begin
                // zero code removes the source's supply entirely
                source_enable_o[i] <= active[i];                                 // see [R9] [R12]
                dac_code_o[i * 6 +: 6] <= active[i] ? act_q[i + 1][5:0] : 6'h00; // see [R8]
                open_drain_mode_o[i] <= is_gpo(act_q[i + 1]);                    // see [R10]
                open_drain_pull_o[i] <= is_gpo(act_q[i + 1]) &&
                                        act_q[i + 1][`GPO_PULL_BIT];             // see [R10]
            end
        end
    end

endmodule
`default_nettype wire

// [logic/led_pump_pkg.sv]
// Purpose: shared types of the pump mode controller
// Assumes: nothing beyond the register header
// Notes: one-hot mode codes
`default_nettype none
package led_pump_pkg;
    typedef enum logic [2:0]
    {
        MODE_1X   = 3'b001,
        MODE_HALF = 3'b010,
        MODE_DBL  = 3'b100
    } pump_mode_t;
    typedef logic [7:0] data_t;
endpackage
`default_nettype wire

// [logic/led_pump_regs.svh]
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock, registers reached over a plain strobe port
// Notes: included by the pump mode controller
//
// Notes on behaviour
// [R1] start in unity mode after reset or shutdown
// [R2] qualified dropout in unity steps to 1.5x
// [R3] further qualified dropout in 1.5x steps to 2x
// [R4] dropout must persist about 400 us first
// [R5] load, ramp-down end, enable fall, blink: unity
// [R6] command register can force any pump mode
// [R7] ignore idle channels and gated-off enable channels
// [R8] nine channels, 6-bit linear current code
// [R9] all-zero data disables the current source
// [R10] top two bits set selects open-drain output
// [R11] open-drain channels never report dropout
// [R12] enable pin rising switches on selected channels
// [R13] enable low, nothing else active: shutdown; the code skips it while D2/D3 force a mode
// [R14] logic supply undervoltage clears all data registers
// [R15] soft-start ramps pump current over 125 us
// [R16] two-phase non-overlapping clock near 850 kHz
// [R17] 1.5x series/parallel, 2x alternate phase charging
// [R18] shutdown closes only the weak bypass switch
// [R19] D2 alone 1.5x, D3 alone 2x, both 1x
// [R20] held settings reach the DACs on load pulse
// [R21] persistence timer restarts when dropout clears early
// [R22] doubling mode holds until a return event
`ifndef LED_PUMP_REGS_SVH
`define LED_PUMP_REGS_SVH

`define ADDR_COMMAND      4'h0
`define ADDR_CH_FIRST     4'h1
`define ADDR_CH_LAST      4'h9
`define ADDR_ENABLE_SEL   4'hA
`define ADDR_ENABLE_SEL_HI 4'hB
`define ADDR_STATUS       4'hC

`define CMD_QUICK_BIT     1
`define CMD_FORCE_HALF_BIT 2
`define CMD_FORCE_DBL_BIT 3
`define DATA_RESET        8'h00
`define GPO_BITS          2'h3
`define GPO_PULL_BIT      0

`define CLK_PERIOD_PS     25000
`define DROPOUT_QUAL_US   400
`define SOFT_START_US     125
`define PUMP_CLK_KHZ      850
`define DROPOUT_QUAL_CYC  ((`DROPOUT_QUAL_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SOFT_START_CYC    ((`SOFT_START_US * 1000000) / `CLK_PERIOD_PS)
`define PUMP_HALF_CYC     (1000000000 / (`PUMP_CLK_KHZ * 2 * `CLK_PERIOD_PS))

`endif

// [tb/dropout_detector_model.sv]
// Purpose: behavioural dropout detectors beside the current sources
// Assumes: headroom request from the bench, one clock
// Notes: reports on any channel, lit or not; filtering is the controller's job
`timescale 1ns/1ps
`default_nettype none
module dropout_detector_model (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [8:0] headroom_low_i,
    output var logic  [8:0] dropout_o
);
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dropout_o <= 9'h000;
        else
            dropout_o <= headroom_low_i;
    end
endmodule
`default_nettype wire

// [tb/led_pump_mode_control_monitor.sv]
// Purpose: port-level checks on the pump mode controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes: attached to every controller instance by the bind below
`timescale 1ns/1ps
`default_nettype none
module led_pump_mode_control_monitor (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       load_pulse_i,
    input wire logic       logic_supply_ok_i,
    input wire logic       external_enable_input_i,
    input wire logic [8:0] dropout_i,
    input wire logic       ramp_down_done_i,
    input wire logic       blink_period_i,
    input wire logic [8:0] source_enable_o,
    input wire logic [8:0] open_drain_mode_o,
    input wire logic [2:0] pump_mode_o,
    input wire logic       shutdown_o,
    input wire logic [7:0] soft_start_level_o,
    input wire logic       phase1_o,
    input wire logic       phase2_o,
    input wire logic       bypass_o,
    input wire logic       weak_bypass_o,
    input wire logic       series_charge_o,
    input wire logic       parallel_stack_o,
    input wire logic       fly_a_charge_o,
    input wire logic       fly_b_charge_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    phase_overlap_a: assert property (
        !(phase1_o && phase2_o)) else $error("pump phases overlap");
    weak_bypass_a: assert property (
        shutdown_o |-> weak_bypass_o && !bypass_o && !series_charge_o && !fly_a_charge_o)
        else $error("shutdown without weak bypass only");
    strong_bypass_a: assert property (
        bypass_o |-> pump_mode_o == 3'b001 && !shutdown_o) else $error("bypass outside 1x");
    half_switch_a: assert property (
        (series_charge_o || parallel_stack_o) |-> pump_mode_o == 3'b010
        && !(series_charge_o && parallel_stack_o)) else $error("1.5x switches misused");
    dbl_switch_a: assert property (
        (fly_a_charge_o || fly_b_charge_o) |-> pump_mode_o == 3'b100
        && !(fly_a_charge_o && fly_b_charge_o)) else $error("2x switches misused");
    dbl_hold_a: assert property (
        (pump_mode_o == 3'b100 && !load_pulse_i && !ramp_down_done_i && !blink_period_i
        && logic_supply_ok_i && $stable(external_enable_input_i))[*3]
        |=> pump_mode_o == 3'b100) else $error("2x left without return event");
    quiet_unity_a: assert property (
        (dropout_i == 9'h000 && !load_pulse_i && pump_mode_o == 3'b001)[*3]
        |=> pump_mode_o == 3'b001) else $error("mode step without dropout");
    ramp_rise_a: assert property (
        (pump_mode_o != 3'b001 && $past(pump_mode_o, 2) == pump_mode_o)
        |-> soft_start_level_o >= $past(soft_start_level_o)) else $error("soft-start fell");
    unity_ramp_a: assert property (
        pump_mode_o == 3'b001 |-> soft_start_level_o == 8'h00) else $error("ramp in 1x");
    od_exclusive_a: assert property (
        (open_drain_mode_o & source_enable_o) == 9'h000) else $error("open drain and source");
endmodule

bind led_pump_mode_control led_pump_mode_control_monitor u_mon (.clock_i, .rst_n_i,
    .load_pulse_i, .logic_supply_ok_i, .external_enable_input_i, .dropout_i,
    .ramp_down_done_i, .blink_period_i, .source_enable_o, .open_drain_mode_o, .pump_mode_o,
    .shutdown_o, .soft_start_level_o, .phase1_o, .phase2_o, .bypass_o, .weak_bypass_o,
    .series_charge_o, .parallel_stack_o, .fly_a_charge_o, .fly_b_charge_o);
`default_nettype wire

// [tb/led_pump_mode_control_tb.sv]
// Purpose: self-checking bench for the pump mode controller
// Assumes: shortened qualification and soft-start counts
// Notes: one task per scenario, register port driven by strobes
`timescale 1ns/1ps
`default_nettype none
module led_pump_mode_control_tb;
    import led_pump_pkg::*;
    localparam int DQ = 20;
    localparam int SS = 50;
    logic        clock_i, rst_n_i, wr, rd, load, supply_ok, pin, ramp, blink;
    logic [3:0]  addr;
    data_t       wdata;
    logic [7:0]  rdata, level;
    logic [8:0]  head, drop, src, odm, odp;
    logic [53:0] dac;
    logic [2:0]  mode;
    logic        shut, ph1, ph2, byp, wbyp, ser, par, fa, fb;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;
    dropout_detector_model u_det (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .headroom_low_i(head), .dropout_o(drop));
    led_pump_mode_control #(.DROP_QUAL_CYC(DQ), .SOFT_START_CYC(SS)) u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .load_pulse_i(load), .logic_supply_ok_i(supply_ok),
        .external_enable_input_i(pin), .dropout_i(drop), .ramp_down_done_i(ramp),
        .blink_period_i(blink), .dac_code_o(dac), .source_enable_o(src),
        .open_drain_mode_o(odm), .open_drain_pull_o(odp), .pump_mode_o(mode),
        .shutdown_o(shut), .soft_start_level_o(level), .phase1_o(ph1), .phase2_o(ph2),
        .bypass_o(byp), .weak_bypass_o(wbyp), .series_charge_o(ser), .parallel_stack_o(par),
        .fly_a_charge_o(fa), .fly_b_charge_o(fb));
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // a run this short never needs more than a few thousand cycles
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input logic [53:0] got, input logic [53:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input data_t d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, "read data");
    endtask
    // 0 load pulse, 1 ramp-down end, 2 blink period end
    task automatic ev(input int k);
        @(posedge clock_i);
        load <= (k == 0);
        ramp <= (k == 1);
        blink <= (k == 2);
        @(posedge clock_i);
        {load, ramp, blink} <= 3'b000;
    endtask
    task automatic hold(input logic [8:0] m, input int n);
        @(posedge clock_i);
        head <= m;
        repeat (n) @(posedge clock_i);
        head <= 9'h000;
        idle(3);
    endtask
    task automatic t_reset();
        int cnt;
        logic prev;
        idle(1);
        chk(mode, 3'b001, "start mode");
        chk({shut, wbyp, byp}, 3'b110, "shutdown bypass");
        rd_chk(4'hC, 8'h09);
        rd_chk(4'hD, 8'h00);
        cnt = 0;
        prev = ph1;
        repeat (940)
        begin
            idle(1);
            if (ph1 && !prev)
                cnt++;
            prev = ph1;
        end
        chk(cnt >= 19 && cnt <= 21, 1'b1, "pump clock rate");
        $display("reset test done");
    endtask
    task automatic t_dac();
        logic [53:0] exp;
        exp = '0;
        for (int i = 0; i < 9; i++)
        begin
            wr_reg(4'(i + 1), 8'h01 + 8'(i * 7));
            exp[i * 6 +: 6] = 6'h01 + 6'(i * 7);
        end
        idle(2);
        chk(dac, 54'h0, "codes before load");
        ev(0);
        idle(3);
        chk(dac, exp, "dac codes");
        chk(src, 9'h1FF, "sources on");
        wr_reg(4'h5, 8'h00);
        ev(0);
        idle(3);
        chk({src, dac[29:24]}, {9'h1EF, 6'h00}, "zero disables");
        $display("dac test done");
    endtask
    task automatic t_od();
        wr_reg(4'h2, 8'hC1);
        ev(0);
        idle(3);
        chk({odm, odp, src[1]}, {9'h002, 9'h002, 1'b0}, "open drain");
        hold(9'h002, DQ + 10);
        chk(mode, 3'b001, "open drain dropout");
        $display("open drain test done");
    endtask
    task automatic t_step();
        hold(9'h001, DQ - 5);
        chk(mode, 3'b001, "short dropout");
        hold(9'h001, DQ + 5);
        idle(SS / 2);
        chk(level > 8'h00 && level < 8'hFF, 1'b1, "mid ramp");
        idle(SS);
        chk({mode, level}, {3'b010, 8'hFF}, "1.5x ramped");
        hold(9'h001, DQ + 5);
        chk(mode, 3'b100, "2x step");
        hold(9'h001, DQ + 25);
        chk(mode, 3'b100, "2x stays");
        for (int k = 0; k < 3; k++)
        begin
            ev(k);
            idle(3);
            chk(mode, 3'b001, "return event");
            hold(9'h001, DQ + 5);
            chk(mode, 3'b010, "step again");
        end
        $display("step test done");
    endtask
    task automatic t_force();
        data_t      cmd [3] = '{8'h04, 8'h08, 8'h0C};
        logic [2:0] exp [3] = '{3'b010, 3'b100, 3'b001};
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(4'h0, cmd[k]);
            ev(0);
            hold(9'h001, DQ + 5);
            chk(mode, exp[k], "forced mode");
        end
        wr_reg(4'h0, 8'h00);
        ev(0);
        idle(3);
        chk(mode, 3'b001, "auto again");
        $display("force test done");
    endtask
    task automatic t_uvlo();
        @(posedge clock_i);
        supply_ok <= 1'b0;
        idle(3);
        chk({dac, src, shut}, {54'h0, 9'h000, 1'b1}, "supply low clears");
        @(posedge clock_i);
        supply_ok <= 1'b1;
        rd_chk(4'h1, 8'h00);
        $display("supply test done");
    endtask
    task automatic t_enable();
        wr_reg(4'h1, 8'h10);
        wr_reg(4'h3, 8'h10);
        wr_reg(4'hA, 8'h04);
        ev(0);
        idle(3);
        chk(src, 9'h001, "pin low");
        hold(9'h004, DQ + 10);
        chk(mode, 3'b001, "gated dropout");
        @(posedge clock_i);
        pin <= 1'b1;
        idle(3);
        chk(src, 9'h005, "pin rise");
        hold(9'h004, DQ + 5);
        chk(mode, 3'b010, "pin dropout");
        @(posedge clock_i);
        pin <= 1'b0;
        idle(3);
        chk({mode, src}, {3'b001, 9'h001}, "pin fall");
        wr_reg(4'h1, 8'h00);
        ev(0);
        pin <= 1'b1;
        idle(3);
        chk(shut, 1'b0, "pin enables");
        @(posedge clock_i);
        pin <= 1'b0;
        idle(3);
        chk(shut, 1'b1, "pin shutdown");
        // quick write fans channel one out to every channel
        wr_reg(4'h0, 8'h02);
        wr_reg(4'h1, 8'h2A);
        rd_chk(4'h9, 8'h2A);
        $display("enable test done");
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        {wr, rd, load, ramp, blink, pin} = 6'h00;
        supply_ok = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        head = 9'h000;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_dac();
        t_od();
        t_step();
        t_force();
        t_uvlo();
        t_enable();
        wrap_up();
    end
endmodule
`default_nettype wire
